// file: hdl/lgpc_led.sv
// LED indicator function generator
`timescale 1ns/1ps
`default_nettype none

module lgpc_led (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic led_function_select,
  input wire logic link_up,
  input wire logic speed_100,
  input wire logic activity,
  lgpc_led_if.source leds
);
  import lgpc_pkg::*;

  // Index 0 duplex, 1 link/activity, 2 speed
  // select-0 set
  always_ff @(posedge core_clk) begin
    if (srst) begin
      leds.led_n <= 3'h7;
    end else if (!led_function_select) begin
      leds.led_n[0] <= ~activity;
      leds.led_n[1] <= ~(link_up & ~activity);
      leds.led_n[2] <= ~speed_100;
    end else begin
      leds.led_n[0] <= ~activity;
      leds.led_n[1] <= ~link_up;
      leds.led_n[2] <= ~speed_100;
    end
  end
endmodule

`default_nettype wire

// file: hdl/lgpc_led_if.sv
// Carrier for the three LED indicator levels
`timescale 1ns/1ps
`default_nettype none

interface lgpc_led_if;
  // Active low: 0 lights the LED
  logic [2:0] led_n;
  modport source (output led_n);
  modport sink (input led_n);
endinterface

`default_nettype wire

// file: hdl/lgpc_pin.sv
// One multi-purpose pin: input synchroniser and output driver
`timescale 1ns/1ps
`default_nettype none

module lgpc_pin (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic pin_in,
  input wire logic drive_val,
  input wire logic drive_en,
  input wire logic push_pull,
  output logic pin_out,
  output logic pin_oe,
  output logic pin_level
);
  import lgpc_pkg::*;

  logic [2:0] sync_r;

  // ****************************************************************
  // Input sampling
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sync_r <= LGPC_SYNC_RST;
    end else begin
      sync_r <= {sync_r[1:0], pin_in};
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      pin_level <= 1'b0;
    end else if (sync_r[1] == sync_r[2]) begin
      pin_level <= sync_r[2];
    end
  end

  // ****************************************************************
  // Output driver
  // ****************************************************************
  // open drain only pulls low
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
    end else begin
      pin_out <= push_pull ? drive_val : 1'b0;
      pin_oe <= drive_en & (push_pull | ~drive_val);
    end
  end
endmodule

`default_nettype wire

// file: hdl/lgpc_pkg.sv
// Constants and types for the LED and pin configuration block
package lgpc_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int unsigned LGPC_ADDR_W = 8;
  localparam logic [7:0] LGPC_LED_PIN_CONFIG_OFS = 8'h24;
  localparam int unsigned LGPC_NPINS = 3;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int unsigned LGPC_SEL_BIT = 31;
  localparam int unsigned LGPC_CTL10_LSB = 24;
  localparam int unsigned LGPC_CTL9_LSB = 20;
  localparam int unsigned LGPC_CTL8_LSB = 16;
  localparam int unsigned LGPC_BUF_LSB = 8;
  localparam int unsigned LGPC_DIR_LSB = 4;
  localparam int unsigned LGPC_DATA_LSB = 0;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic LGPC_SEL_RST = 1'b0;
  localparam logic [1:0] LGPC_CTL_RST = 2'h0;
  localparam logic [2:0] LGPC_BUF_RST = 3'h0;
  localparam logic [2:0] LGPC_DIR_RST = 3'h0;
  localparam logic [2:0] LGPC_DATA_RST = 3'h0;
  localparam logic [2:0] LGPC_SYNC_RST = 3'h0;

  // ****************************************************************
  // Pin function codes
  // ****************************************************************
  typedef enum logic [1:0] {
    lgpc_fn_gpio = 2'h0,
    lgpc_fn_led = 2'h1,
    lgpc_fn_mirror_a = 2'h2,
    lgpc_fn_mirror_b = 2'h3
  } lgpc_fn_e;

endpackage

// file: hdl/lgpc_top.sv
// LED and multi-purpose pin configuration register with pin logic
//
// Function
// - Select 0: speed, link-activity, duplex LEDs
// - Select 0 duplex pin shows activity
// - Select resets 0, or EEPROM flag
// - USB/lite reset restores image or 0
// - Pin 10 field picks function
// - Pin 9: gpio, LED, RXD1, PHY reset
// - Pin 8: gpio, LED, RXD2, CRS
// - Mirror codes drive live MII signal, or PHY reset on pin 9
// - Code 01 routes selected LED function
// - Direction bit set makes pin output
// - Data written drives; read shows pin
// - Data read follows pin after reset
`timescale 1ns/1ps
`default_nettype none

module lgpc_top (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic usb_reset,
  input wire logic lite_reset,
  input wire logic eeprom_present,
  input wire logic eeprom_load_done,
  input wire logic eeprom_led_select,
  input wire logic [lgpc_pkg::LGPC_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic link_up,
  input wire logic speed_100,
  input wire logic activity,
  input wire logic [3:0] mii_rxd,
  input wire logic mii_crs,
  input wire logic phy_reset_out_n,
  input wire logic [2:0] pin_in,
  output logic [2:0] pin_out,
  output logic [2:0] pin_oe,
  output logic led_function_select
);
  import lgpc_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic led_image_r;
  lgpc_fn_e pin10_function_field_r;
  lgpc_fn_e pin9_function_field_r;
  lgpc_fn_e pin8_function_field_r;
  logic [2:0] pin_buffer_type_bits_r;
  logic [2:0] pin_direction_bits_r;
  logic [2:0] pin_data_bits_r;
  logic [2:0] pin_level;
  logic [2:0] drive_val;
  logic [2:0] drive_en;
  logic [2:0] push_pull;
  logic [2:0] mirror_a;
  logic [2:0] mirror_b;
  logic [1:0] fn_code [LGPC_NPINS];
  logic soft_reset;
  logic cfg_hit;
  logic cfg_wr;
  logic cfg_rd;
  logic [31:0] cfg_word;
  logic cfg_clr;
  logic led_select_nxt;
  logic sel_restore;
  logic wr_sel;
  logic [1:0] wr_ctl10;
  logic [1:0] wr_ctl9;
  logic [1:0] wr_ctl8;
  logic [2:0] wr_buf;
  logic [2:0] wr_dir;
  logic [2:0] wr_data;
  lgpc_fn_e pin10_function_field_nxt;
  lgpc_fn_e pin9_function_field_nxt;
  lgpc_fn_e pin8_function_field_nxt;
  logic [2:0] pin_buffer_type_bits_nxt;
  logic [2:0] pin_direction_bits_nxt;
  logic [2:0] pin_data_bits_nxt;
  logic speed_indicator_pin_n;
  logic link_activity_pin_n;
  logic duplex_indicator_pin_n;
  logic [2:0] led_for_pin;

  lgpc_led_if led_bus ();

  // ****************************************************************
  // Register decode
  // ****************************************************************
  assign cfg_hit = (reg_addr == LGPC_LED_PIN_CONFIG_OFS);
  assign cfg_wr = reg_wr & cfg_hit;
  assign cfg_rd = reg_rd & cfg_hit;
  assign soft_reset = usb_reset | lite_reset;
  assign cfg_clr = srst | soft_reset;

  // ****************************************************************
  // Write data fields
  // ****************************************************************
  // reserved write bits never picked up
  assign wr_sel = reg_wdata[LGPC_SEL_BIT];
  assign wr_ctl10 = reg_wdata[LGPC_CTL10_LSB +: 2];
  assign wr_ctl9 = reg_wdata[LGPC_CTL9_LSB +: 2];
  assign wr_ctl8 = reg_wdata[LGPC_CTL8_LSB +: 2];
  assign wr_buf = reg_wdata[LGPC_BUF_LSB +: 3];
  assign wr_dir = reg_wdata[LGPC_DIR_LSB +: 3];
  assign wr_data = reg_wdata[LGPC_DATA_LSB +: 3];

  // ****************************************************************
  // LED function select
  // ****************************************************************
  // Image keeps the last value loaded from the EEPROM
  always_ff @(posedge core_clk) begin
    if (srst) begin
      led_image_r <= LGPC_SEL_RST;
    end else if (eeprom_load_done) begin
      led_image_r <= eeprom_led_select;
    end
  end

  // value a USB or lite reset restores
  assign sel_restore = eeprom_present ? led_image_r : LGPC_SEL_RST;

  // EEPROM load, soft reset wins over it and writes
  always_comb begin
    led_select_nxt = led_function_select;
    if (soft_reset) begin
      led_select_nxt = sel_restore;
    end else if (eeprom_load_done) begin
      led_select_nxt = eeprom_present ? eeprom_led_select : LGPC_SEL_RST;
    end else if (cfg_wr) begin
      led_select_nxt = wr_sel;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      led_function_select <= LGPC_SEL_RST;
    end else begin
      led_function_select <= led_select_nxt;
    end
  end

  // ****************************************************************
  // Next values of the pin fields
  // ****************************************************************
  // Fields take the write word only on a hit to the register
  always_comb begin
    pin10_function_field_nxt = pin10_function_field_r;
    pin9_function_field_nxt = pin9_function_field_r;
    pin8_function_field_nxt = pin8_function_field_r;
    pin_buffer_type_bits_nxt = pin_buffer_type_bits_r;
    pin_direction_bits_nxt = pin_direction_bits_r;
    pin_data_bits_nxt = pin_data_bits_r;
    if (cfg_wr) begin
      pin10_function_field_nxt = lgpc_fn_e'(wr_ctl10);
      pin9_function_field_nxt = lgpc_fn_e'(wr_ctl9);
      pin8_function_field_nxt = lgpc_fn_e'(wr_ctl8);
      pin_buffer_type_bits_nxt = wr_buf;
      pin_direction_bits_nxt = wr_dir;
      pin_data_bits_nxt = wr_data;
    end
  end

  // ****************************************************************
  // Pin function fields
  // ****************************************************************
  // pin 10 field
  always_ff @(posedge core_clk) begin
    if (cfg_clr) begin
      pin10_function_field_r <= lgpc_fn_e'(LGPC_CTL_RST);
    end else begin
      pin10_function_field_r <= pin10_function_field_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (cfg_clr) begin
      pin9_function_field_r <= lgpc_fn_e'(LGPC_CTL_RST);
    end else begin
      pin9_function_field_r <= pin9_function_field_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (cfg_clr) begin
      pin8_function_field_r <= lgpc_fn_e'(LGPC_CTL_RST);
    end else begin
      pin8_function_field_r <= pin8_function_field_nxt;
    end
  end

  // ****************************************************************
  // Buffer, direction and data bits
  // ****************************************************************
  // buffer type storage
  always_ff @(posedge core_clk) begin
    if (cfg_clr) begin
      pin_buffer_type_bits_r <= LGPC_BUF_RST;
    end else begin
      pin_buffer_type_bits_r <= pin_buffer_type_bits_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (cfg_clr) begin
      pin_direction_bits_r <= LGPC_DIR_RST;
    end else begin
      pin_direction_bits_r <= pin_direction_bits_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (cfg_clr) begin
      pin_data_bits_r <= LGPC_DATA_RST;
    end else begin
      pin_data_bits_r <= pin_data_bits_nxt;
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  // reserved positions held at zero
  // data field returns live pin level
  always_comb begin
    cfg_word = 32'h0000_0000;
    cfg_word[LGPC_SEL_BIT] = led_function_select;
    cfg_word[LGPC_CTL10_LSB +: 2] = pin10_function_field_r;
    cfg_word[LGPC_CTL9_LSB +: 2] = pin9_function_field_r;
    cfg_word[LGPC_CTL8_LSB +: 2] = pin8_function_field_r;
    cfg_word[LGPC_BUF_LSB +: 3] = pin_buffer_type_bits_r;
    cfg_word[LGPC_DIR_LSB +: 3] = pin_direction_bits_r;
    cfg_word[LGPC_DATA_LSB +: 3] = pin_level;
  end

  // Data stand only in the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (srst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (cfg_rd) begin
      reg_rdata <= cfg_word;
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // ****************************************************************
  // LED functions
  // ****************************************************************
  lgpc_led u_led (
    .core_clk(core_clk),
    .srst(srst),
    .led_function_select(led_function_select),
    .link_up(link_up),
    .speed_100(speed_100),
    .activity(activity),
    .leds(led_bus.source)
  );

  // ****************************************************************
  // LED levels by pin, index 0 is pin 8
  // ****************************************************************
  // duplex on pin 8, link on 9, speed on 10
  assign duplex_indicator_pin_n = led_bus.led_n[0];
  assign link_activity_pin_n = led_bus.led_n[1];
  assign speed_indicator_pin_n = led_bus.led_n[2];
  assign led_for_pin = {speed_indicator_pin_n, link_activity_pin_n, duplex_indicator_pin_n};

  // ****************************************************************
  // Mirror sources, index 0 is pin 8
  // ****************************************************************
  // pin 9 mirrors RXD1 or PHY reset
  // pin 8 mirrors RXD2 or CRS
  assign mirror_a = {mii_rxd[0], mii_rxd[1], mii_rxd[2]};
  assign mirror_b = {mii_rxd[3], phy_reset_out_n, mii_crs};

  assign fn_code[0] = pin8_function_field_r;
  assign fn_code[1] = pin9_function_field_r;
  assign fn_code[2] = pin10_function_field_r;

  // ****************************************************************
  // Per-pin function multiplexer and driver
  // ****************************************************************
  for (genvar i = 0; i < LGPC_NPINS; i++) begin : g_pin
    always_comb begin
      drive_val[i] = 1'b0;
      drive_en[i] = 1'b0;
      push_pull[i] = pin_buffer_type_bits_r[i];
      case (lgpc_fn_e'(fn_code[i]))
        lgpc_fn_gpio: begin
          drive_val[i] = pin_data_bits_r[i];
          drive_en[i] = pin_direction_bits_r[i];
        end
        lgpc_fn_led: begin
          drive_val[i] = led_for_pin[i];
          drive_en[i] = 1'b1;
        end
        lgpc_fn_mirror_a: begin
          drive_val[i] = mirror_a[i];
          drive_en[i] = 1'b1;
          push_pull[i] = 1'b1;
        end
        lgpc_fn_mirror_b: begin
          drive_val[i] = mirror_b[i];
          drive_en[i] = 1'b1;
          push_pull[i] = 1'b1;
        end
        default: begin
          drive_val[i] = 1'b0;
          drive_en[i] = 1'b0;
        end
      endcase
    end

    lgpc_pin u_pin (
      .core_clk(core_clk),
      .srst(srst),
      .pin_in(pin_in[i]),
      .drive_val(drive_val[i]),
      .drive_en(drive_en[i]),
      .push_pull(push_pull[i]),
      .pin_out(pin_out[i]),
      .pin_oe(pin_oe[i]),
      .pin_level(pin_level[i])
    );
  end

endmodule

`default_nettype wire

// file: test/lgpc_board.sv
// Board model: pad levels from device drive, board drivers and pull-ups
`timescale 1ns/1ps
`default_nettype none
module lgpc_board (
  input wire logic [2:0] pin_out,
  input wire logic [2:0] pin_oe,
  input wire logic [2:0] ext_en,
  input wire logic [2:0] ext_val,
  output logic [2:0] pin_in
);
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
    end
  end
endmodule
`default_nettype wire

// file: test/lgpc_top_bench.sv
// Directed bench for the LED and pin configuration block
`timescale 1ns/1ps
`default_nettype none
module lgpc_top_bench;
  import lgpc_pkg::*;
  logic core_clk = 1'b0, srst = 1'b1, usb_reset = 1'b0, lite_reset = 1'b0;
  logic eeprom_present = 1'b0, eeprom_load_done = 1'b0, eeprom_led_select = 1'b0;
  logic [7:0] reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, rd_v;
  logic reg_wr = 1'b0, reg_rd = 1'b0, link_up = 1'b0, speed_100 = 1'b0, activity = 1'b0;
  logic [3:0] mii_rxd = 4'h0;
  logic mii_crs = 1'b0, phy_reset_out_n = 1'b1, led_function_select;
  logic [2:0] ext_en = 3'h0, ext_val = 3'h0, pin_in, pin_out, pin_oe;
  int error_cnt = 0, num_checks = 0;
  always #25 core_clk = ~core_clk;
  lgpc_top uut (.core_clk, .srst, .usb_reset, .lite_reset, .eeprom_present, .eeprom_load_done,
    .eeprom_led_select, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .link_up,
    .speed_100, .activity, .mii_rxd, .mii_crs, .phy_reset_out_n, .pin_in, .pin_out, .pin_oe,
    .led_function_select);
  lgpc_board brd (.pin_out, .pin_oe, .ext_en, .ext_val, .pin_in);
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 rd_v = reg_rdata;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge core_clk);
    srst <= 1'b0;
    tick(6);
    rd(8'h24);
    chk("reset word", rd_v, 32'h0000_0007);
    wr(8'h28, 32'hFFFF_FFFF);
    rd(8'h28);
    chk("unmapped read", rd_v, 32'h0);
    rd(8'h24);
    chk("word after stray write", rd_v, 32'h0000_0007);
    mii_crs <= 1'b1;
    phy_reset_out_n <= 1'b0;
    mii_rxd <= 4'h8;
    wr(8'h24, 32'hFFFF_FFFF);
    tick(6);
    chk("mirror 11 out", 32'(pin_out), 32'h5);
    chk("mirror oe", 32'(pin_oe), 32'h7);
    rd(8'h24);
    chk("all ones word", rd_v, 32'h8333_0775);
    mii_crs <= 1'b0;
    tick(3);
    chk("crs follows", 32'(pin_out), 32'h4);
    mii_rxd <= 4'h6;
    wr(8'h24, 32'h0222_0000);
    tick(3);
    chk("mirror 10 out", 32'(pin_out), 32'h3);
    wr(8'h24, 32'h0000_0775);
    tick(6);
    chk("push-pull out", 32'(pin_out), 32'h5);
    chk("push-pull oe", 32'(pin_oe), 32'h7);
    rd(8'h24);
    chk("push-pull word", rd_v, 32'h0000_0775);
    wr(8'h24, 32'h0000_0075);
    tick(6);
    chk("open-drain out", 32'(pin_out), 32'h0);
    chk("open-drain oe", 32'(pin_oe), 32'h2);
    ext_en <= 3'h1;
    tick(6);
    rd(8'h24);
    chk("open-drain pulled low", rd_v, 32'h0000_0074);
    // wake candidates set as inputs first
    // wake enable lives outside, none here
    ext_en <= 3'h7;
    ext_val <= 3'h2;
    wr(8'h24, 32'h0);
    tick(6);
    chk("input oe", 32'(pin_oe), 32'h0);
    rd(8'h24);
    chk("input level", rd_v, 32'h0000_0002);
    ext_en <= 3'h0;
    link_up <= 1'b1;
    speed_100 <= 1'b1;
    activity <= 1'b1;
    wr(8'h24, 32'h0111_0700);
    tick(4);
    chk("led select 0", 32'(pin_out), 32'h2);
    wr(8'h24, 32'h8111_0700);
    tick(4);
    chk("led select 1", 32'(pin_out), 32'h0);
    eeprom_present <= 1'b1;
    eeprom_led_select <= 1'b1;
    eeprom_load_done <= 1'b1;
    @(posedge core_clk);
    eeprom_load_done <= 1'b0;
    tick(1);
    chk("select loaded", 32'(led_function_select), 32'h1);
    wr(8'h24, 32'h0000_0770);
    tick(1);
    chk("select written", 32'(led_function_select), 32'h0);
    usb_reset <= 1'b1;
    @(posedge core_clk);
    usb_reset <= 1'b0;
    tick(6);
    rd(8'h24);
    chk("usb reset word", rd_v, 32'h8000_0007);
    eeprom_present <= 1'b0;
    lite_reset <= 1'b1;
    @(posedge core_clk);
    lite_reset <= 1'b0;
    tick(2);
    chk("lite reset select", 32'(led_function_select), 32'h0);
    give_verdict();
  end
endmodule
`default_nettype wire

// file: test/lgpc_top_props.sv
// Port checks for the LED and pin configuration block
`timescale 1ns/1ps
`default_nettype none
module lgpc_checker
  import lgpc_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic usb_reset,
  input wire logic lite_reset,
  input wire logic eeprom_present,
  input wire logic [lgpc_pkg::LGPC_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic eeprom_load_done,
  input wire logic [31:0] reg_rdata,
  input wire logic mii_crs,
  input wire logic [2:0] pin_out,
  input wire logic [2:0] pin_oe,
  input wire logic led_function_select
);
  logic [31:0] cfg_r;
  logic cfg_wr;
  assign cfg_wr = reg_wr && reg_addr == LGPC_LED_PIN_CONFIG_OFS;
  // Shadow of the writable pin fields, select bit 31 excluded
  always_ff @(posedge core_clk) begin
    if (srst || usb_reset || lite_reset) begin
      cfg_r <= 32'h0;
    end else if (cfg_wr) begin
      cfg_r <= reg_wdata & 32'h0333_0777;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  sequence s_soft;
    (usb_reset || lite_reset) ##1 !reg_wr;
  endsequence
  a_rd_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data not idle");
  a_rsvd_zero: assert property (reg_rd |=> (reg_rdata & 32'h7CCC_F888) == 32'h0)
    else $error("reserved bits not zero");
  a_sel_read: assert property (reg_rd && reg_addr == LGPC_LED_PIN_CONFIG_OFS
    |=> reg_rdata[31] == $past(led_function_select)) else $error("select read wrong");
  a_sel_write: assert property (cfg_wr && !usb_reset && !lite_reset && !eeprom_load_done
    |=> led_function_select == $past(reg_wdata[31])) else $error("select write lost");
  a_soft_sel: assert property ((usb_reset || lite_reset) && !eeprom_present
    |=> !led_function_select) else $error("select not restored");
  a_soft_oe: assert property (s_soft |=> pin_oe == 3'h0)
    else $error("pins driven after soft reset");
  a_reset_exit: assert property ($fell(srst) |-> pin_oe == 3'h0 && reg_rdata == 32'h0
    && !led_function_select) else $error("reset state wrong");
  a_mirror_crs: assert property ($past(cfg_r[17:16]) == 2'h3
    |-> pin_out[0] == $past(mii_crs) && pin_oe[0]) else $error("pin8 mirror wrong");
  a_gpio_pp: assert property ($past(cfg_r[17:16]) == 2'h0 && $past(cfg_r[8])
    |-> pin_out[0] == $past(cfg_r[0]) && pin_oe[0] == $past(cfg_r[4]))
    else $error("pin8 push-pull wrong");
  a_gpio_od: assert property ($past(cfg_r[21:20]) == 2'h0 && !$past(cfg_r[9])
    |-> !pin_out[1] && pin_oe[1] == ($past(cfg_r[5]) && !$past(cfg_r[1])))
    else $error("pin9 open-drain wrong");
endmodule
bind lgpc_top lgpc_checker u_chk (.core_clk, .srst, .usb_reset, .lite_reset, .eeprom_present,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .eeprom_load_done, .reg_rdata, .mii_crs, .pin_out,
  .pin_oe, .led_function_select);
`default_nettype wire
